// ===== rtl/mcsos_pkg.sv
// package: register map, field layout, reset values and wait figures of the main clock control
`default_nettype none
package mcsos_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [15:0] MCSOS_ADDR_MODE   = 16'hffa1;
   localparam logic [15:0] MCSOS_ADDR_CTRL   = 16'hffa2;
   localparam logic [15:0] MCSOS_ADDR_STAT   = 16'hffa3;
   localparam logic [15:0] MCSOS_ADDR_WSEL   = 16'hffa4;
   localparam logic [7:0]  MCSOS_RST_MODE    = 8'h00;
   localparam logic [7:0]  MCSOS_RST_CTRL    = 8'h80;
   localparam logic [7:0]  MCSOS_RST_STAT    = 8'h00;
   localparam logic [7:0]  MCSOS_RST_WSEL    = 8'h05;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MCSOS_BIT_STOP   = 7;
   localparam int MCSOS_BIT_XSRC   = 2;
   localparam int MCSOS_BIT_MSTAT  = 1;
   localparam int MCSOS_BIT_MSEL   = 0;
   localparam int MCSOS_WCODE_W    = 3;
   localparam int MCSOS_NSTEPS     = 5;
   // ----------------------------------------------------------------
   // wait lengths in crystal cycles, as powers of two
   // ----------------------------------------------------------------
   localparam int MCSOS_EXP_11 = 11;
   localparam int MCSOS_EXP_13 = 13;
   localparam int MCSOS_EXP_14 = 14;
   localparam int MCSOS_EXP_15 = 15;
   localparam int MCSOS_EXP_16 = 16;
   localparam int MCSOS_CNT_W  = 17;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bit_op;
      logic [2:0] bit_idx;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mcsos_bus_s;

   typedef struct packed {
      logic main_hs;
      logic periph_hs;
      logic osc_enable;
   } mcsos_route_s;
endpackage : mcsos_pkg
`default_nettype wire

// ===== rtl/mcsos_stab_counter.sv
// crystal stabilization counter with sticky step flags
`default_nettype none
module mcsos_stab_counter
   import mcsos_pkg::*;
#(
   parameter int CNT_W = MCSOS_CNT_W
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire logic                    clear,
   input  wire logic                    osc_tick,
   input  wire logic [MCSOS_WCODE_W-1:0] wait_code,
   output var  logic [MCSOS_NSTEPS-1:0] steps,
   output var  logic                    wait_done
);
   typedef struct packed {
      logic [CNT_W-1:0]        cnt;
      logic [MCSOS_NSTEPS-1:0] steps;
   } mcsos_cnt_s;

   mcsos_cnt_s st_q;
   mcsos_cnt_s st_d;
   logic [MCSOS_NSTEPS-1:0] reach;
   logic [CNT_W-1:0]        limit;

   function automatic logic [CNT_W-1:0] code_limit(input logic [MCSOS_WCODE_W-1:0] c);
      case (c)
         3'h1:    code_limit = CNT_W'(1) << MCSOS_EXP_11;
         3'h2:    code_limit = CNT_W'(1) << MCSOS_EXP_13;
         3'h3:    code_limit = CNT_W'(1) << MCSOS_EXP_14;
         3'h4:    code_limit = CNT_W'(1) << MCSOS_EXP_15;
         default: code_limit = CNT_W'(1) << MCSOS_EXP_16; // prohibited codes act as longest
      endcase
   endfunction

   localparam int EXPS [MCSOS_NSTEPS] = '{MCSOS_EXP_16, MCSOS_EXP_15, MCSOS_EXP_14,
                                          MCSOS_EXP_13, MCSOS_EXP_11};

   // step i (bit i) reached when count reaches its power of two
   for (genvar i = 0; i < MCSOS_NSTEPS; i++) begin : g_step
      assign reach[i] = st_q.cnt >= (CNT_W'(1) << EXPS[i]);
   end

   assign limit = code_limit(wait_code);

   always_comb begin
      st_d = st_q;
      if (clear) begin
         st_d = '0;
      end else begin
         if (osc_tick && st_q.cnt < limit) begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
         end
         st_d.steps = st_q.steps | reach;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign steps     = st_q.steps;
   assign wait_done = st_q.cnt >= limit;

   sticky_steps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !clear |=> (st_q.steps & $past(st_q.steps)) == $past(st_q.steps))
      else $error("stabilization flag dropped without clear");
   count_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q.cnt <= limit || $changed(wait_code))
      else $error("stabilization counter ran past selected wait");
endmodule // mcsos_stab_counter
`default_nettype wire

// ===== rtl/mcsos_route.sv
// clock routing decode from source and main select bits
`default_nettype none
module mcsos_route
   import mcsos_pkg::*;
(
   input  wire logic   clk_sys,
   input  wire logic   rst_n,
   input  wire logic   src_sel,
   input  wire logic   main_sel,
   input  wire logic   stop_bit,
   output mcsos_route_s route
);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         route <= '0;
      end else begin
         route.main_hs    <= src_sel & main_sel;
         route.periph_hs  <= src_sel;
         route.osc_enable <= ~stop_bit;
      end
   end
endmodule // mcsos_route
`default_nettype wire

// ===== rtl/mcsos_main_clock_ctrl.sv
// main clock select, oscillator control and stabilization status registers
//
// Operation
// - stop bit 1 halts crystal or blocks external clock; 0 runs it
// - source/main select route main and peripheral clocks to internal or crystal
// - read-only main clock status bit 1 shows main clock source
// - clock source select bit changes only once after reset
// - watchdog, timer h1 low-speed and external-clock peripherals ignore select bits
// - status cleared on reset, stop instruction, and stop bit set
// - status bits set in order at 2^11..2^16 crystal cycles, sticky
// - counter stops at selected wait; later bits stay clear
// - wait codes 1..5 choose 2^11,13,14,15,16 cycles; others prohibited
// - cpu held after stop release until wait passes on crystal clock
// - counted wait starts only once crystal oscillates
// - control/mode take bit or byte writes; wait select byte only; status read-only
`default_nettype none
module mcsos_main_clock_ctrl
   import mcsos_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire mcsos_bus_s  bus,
   input  wire logic        stop_exec,
   input  wire logic        stop_release,
   input  wire logic        osc_tick,
   input  wire logic        cpu_on_crystal,
   output logic [7:0]       rdata,
   output mcsos_route_s     route,
   output logic             cpu_hold
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       stop;
      logic       src_sel;
      logic       src_locked;
      logic       main_sel;
      logic       main_stat;
      logic [2:0] wait_code;
      logic [7:0] rdata;
      logic       hold;
   } mcsos_state_s;

   mcsos_state_s st_q;
   mcsos_state_s st_d;
   logic [MCSOS_NSTEPS-1:0] steps;
   logic                    wait_done;
   logic                    cnt_clear;
   logic                    stop_set;

   // bit writes modify one bit; byte writes take all
   function automatic logic wbit(input mcsos_bus_s b, input int idx, input logic cur);
      if (b.bit_op) begin
         wbit = (b.bit_idx == 3'(idx)) ? b.wdata[0] : cur;
      end else begin
         wbit = b.wdata[idx];
      end
   endfunction

   // ----------------------------------------------------------------
   // register update
   // ----------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      stop_set = 1'b0;
      if (bus.wr) begin
         if (bus.addr == MCSOS_ADDR_CTRL) begin
            st_d.stop = wbit(bus, MCSOS_BIT_STOP, st_q.stop);
            stop_set  = st_d.stop & ~st_q.stop;
         end else if (bus.addr == MCSOS_ADDR_MODE) begin
            st_d.main_sel = wbit(bus, MCSOS_BIT_MSEL, st_q.main_sel);
            if (!st_q.src_locked) begin
               st_d.src_sel = wbit(bus, MCSOS_BIT_XSRC, st_q.src_sel);
               if (st_d.src_sel != st_q.src_sel) begin
                  st_d.src_locked = 1'b1;
               end
            end
         end else if (bus.addr == MCSOS_ADDR_WSEL && !bus.bit_op) begin
            st_d.wait_code = bus.wdata[2:0];
         end
      end
      st_d.main_stat = st_q.src_sel & st_q.main_sel;
      // hold cpu from stop release on crystal clock until the selected wait elapses
      if (stop_release && cpu_on_crystal) begin
         st_d.hold = 1'b1;
      end else if (wait_done) begin
         st_d.hold = 1'b0;
      end
      st_d.rdata = 8'h00;
      if (bus.rd) begin
         if (bus.addr == MCSOS_ADDR_CTRL) begin
            st_d.rdata = {st_q.stop, 7'h00};
         end else if (bus.addr == MCSOS_ADDR_MODE) begin
            st_d.rdata = {5'h00, st_q.src_sel, st_q.main_stat, st_q.main_sel};
         end else if (bus.addr == MCSOS_ADDR_STAT) begin
            st_d.rdata = {3'h0, steps};
         end else if (bus.addr == MCSOS_ADDR_WSEL) begin
            st_d.rdata = {5'h00, st_q.wait_code};
         end
      end
   end

   // ----------------------------------------------------------------
   // counter clearing: stop instruction, stop bit set, stop bit held
   // ----------------------------------------------------------------
   assign cnt_clear = stop_exec | stop_set | st_q.stop;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q           <= '0;
         st_q.stop      <= MCSOS_RST_CTRL[MCSOS_BIT_STOP];
         st_q.wait_code <= MCSOS_RST_WSEL[2:0];
      end else begin
         st_q <= st_d;
      end
   end

   mcsos_stab_counter #(
      .CNT_W (MCSOS_CNT_W)
   ) u_cnt (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .clear     (cnt_clear),
      .osc_tick  (osc_tick & ~st_q.stop),
      .wait_code (st_q.wait_code),
      .steps     (steps),
      .wait_done (wait_done)
   );

   // watchdog and timer h1 clocks are not routed here at all
   mcsos_route u_route (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .src_sel  (st_q.src_sel),
      .main_sel (st_q.main_sel),
      .stop_bit (st_q.stop),
      .route    (route)
   );

   assign rdata    = st_q.rdata;
   assign cpu_hold = st_q.hold;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   src_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q.src_locked |=> $stable(st_q.src_sel))
      else $error("source select changed twice");
   status_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ##1 st_q.main_stat == $past(st_q.src_sel & st_q.main_sel))
      else $error("main status does not follow select");
   route_main_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !st_q.src_sel |=> !route.main_hs && !route.periph_hs)
      else $error("internal source not routed");
   route_periph_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q.src_sel |=> route.periph_hs)
      else $error("peripheral clock not on crystal");
   route_both_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q.src_sel && st_q.main_sel |=> route.main_hs)
      else $error("main clock not on crystal");
   osc_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q.stop |=> !route.osc_enable)
      else $error("oscillator enabled while stopped");
   osc_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !st_q.stop |=> route.osc_enable)
      else $error("oscillator not enabled while running");
   stop_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stop_exec |=> steps == '0)
      else $error("status not cleared by stop instruction");
   stopbit_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      st_q.stop |=> steps == '0)
      else $error("status not cleared by stop bit");
   step_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (steps[3:0] & ~steps[4:1]) == 4'h0)
      else $error("stabilization flags out of order");
   stat_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      bus.rd && bus.addr == MCSOS_ADDR_STAT |=> rdata == {3'h0, $past(steps)})
      else $error("status read with wrong bit order");
   hold_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stop_release && cpu_on_crystal && !wait_done |=> cpu_hold)
      else $error("cpu not held after stop release");
   hold_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cpu_hold && wait_done && !stop_release |=> !cpu_hold)
      else $error("cpu held past selected wait");
   wsel_byte_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      bus.wr && bus.bit_op && bus.addr == MCSOS_ADDR_WSEL |=> $stable(st_q.wait_code))
      else $error("wait select took a bit write");

   src_change_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(st_q.src_sel));
   hold_end_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(cpu_hold));
   all_steps_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      steps == 5'h1f);
   stat_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      bus.rd && bus.addr == MCSOS_ADDR_STAT && steps != '0);
   hold_start_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(cpu_hold));
endmodule // mcsos_main_clock_ctrl
`default_nettype wire

// ===== testbench/tb.sv
// bench: main clock control block checked against a behavioural model
`default_nettype none
module tb
   import mcsos_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         clk_sys = 1'b0;
   logic         rst_n = 1'b0;
   mcsos_bus_s   bus = '0;
   logic         stop_exec = 1'b0;
   logic         stop_release = 1'b0;
   logic         osc_tick = 1'b0;
   logic         cpu_on_crystal = 1'b0;
   logic [7:0]   rdata;
   mcsos_route_s route;
   logic         cpu_hold;
   int           err_total = 0;
   int           samples_checked = 0;
   int           seed = 32'h16877ba7;
   int           r;
   int           m_src, m_chg, m_msel, m_stop, m_wsel, m_cnt, m_hold;
   int           exps [5] = '{11, 13, 14, 15, 16};
   logic [15:0]  addrs [5] = '{MCSOS_ADDR_MODE, MCSOS_ADDR_CTRL, MCSOS_ADDR_STAT,
                              MCSOS_ADDR_WSEL, 16'hffa5};

   mcsos_main_clock_ctrl dut (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .bus            (bus),
      .stop_exec      (stop_exec),
      .stop_release   (stop_release),
      .osc_tick       (osc_tick),
      .cpu_on_crystal (cpu_on_crystal),
      .rdata          (rdata),
      .route          (route),
      .cpu_hold       (cpu_hold)
   );

   always #5 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // model and checks
   // ----------------------------------------------------------------
   // prohibited wait codes behave as the longest wait
   function automatic int lim();
      return (m_wsel >= 1 && m_wsel <= 5) ? (1 << exps[m_wsel-1]) : (1 << 16);
   endfunction

   function automatic logic [7:0] model_rd(logic [15:0] a);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 5; i++) begin
         s[4-i] = (m_cnt >= (1 << exps[i]));
      end
      case (a)
         MCSOS_ADDR_MODE: return {5'h00, m_src[0], m_src[0] & m_msel[0], m_msel[0]};
         MCSOS_ADDR_CTRL: return {m_stop[0], 7'h00};
         MCSOS_ADDR_STAT: return s;
         MCSOS_ADDR_WSEL: return {5'h00, m_wsel[2:0]};
         default:         return 8'h00;
      endcase
   endfunction

   task automatic chk_rd(logic [7:0] got, logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t rdata %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_out(logic [3:0] got, logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t route_hold %h exp %h", $time, got, exp);
      end
   endtask

   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask

   // route and hold are levels, so two edges after the cause they must stand
   task automatic outs();
      repeat (2) step();
      chk_out({route, cpu_hold}, {m_src[0] & m_msel[0], m_src[0], ~m_stop[0], m_hold[0]});
   endtask

   task automatic rd(logic [15:0] a);
      step();
      bus.rd = 1'b1;
      bus.addr = a;
      step();
      bus.rd = 1'b0;
      chk_rd(rdata, model_rd(a));
   endtask

   task automatic wr(logic [15:0] a, logic [7:0] d, logic bop, logic [2:0] idx);
      logic [7:0] v;
      v = model_rd(a);
      v[idx] = d[0];
      if (!bop) v = d;
      step();
      bus = '{wr: 1'b1, rd: 1'b0, bit_op: bop, bit_idx: idx, addr: a, wdata: d};
      step();
      bus.wr = 1'b0;
      if (a == MCSOS_ADDR_MODE) begin
         if (m_chg == 0 && v[2] != m_src[0]) begin
            m_src = v[2];
            m_chg = 1;
         end
         m_msel = v[0];
      end
      if (a == MCSOS_ADDR_CTRL) begin
         if (v[7] != m_stop[0]) m_cnt = 0;
         m_stop = v[7];
      end
      if (a == MCSOS_ADDR_WSEL && !bop) m_wsel = v[2:0];
      outs();
   endtask

   task automatic tick(int n);
      repeat (n) begin
         step();
         osc_tick = 1'b1;
         if (m_stop == 0 && m_cnt < lim()) m_cnt++;
      end
      step();
      osc_tick = 1'b0;
      if (m_cnt >= lim()) m_hold = 0;
   endtask

   task automatic pulse(logic ex);
      step();
      stop_exec = ex;
      stop_release = !ex;
      step();
      stop_exec = 1'b0;
      stop_release = 1'b0;
      if (ex) m_cnt = 0;
      else m_hold = cpu_on_crystal;
      outs();
   endtask

   task automatic mreset();
      m_src = 0;
      m_chg = 0;
      m_msel = 0;
      m_stop = 1;
      m_wsel = 5;
      m_cnt = 0;
      m_hold = 0;
   endtask

   task automatic conclude();
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      mreset();
      repeat (5) step();
      rst_n = 1'b1;
      foreach (addrs[i]) rd(addrs[i]);
      wr(MCSOS_ADDR_WSEL, 8'h03, 1'b1, 3'd1);
      wr(MCSOS_ADDR_STAT, 8'hff, 1'b0, 3'd0);
      rd(MCSOS_ADDR_WSEL);
      rd(MCSOS_ADDR_STAT);
      r = $random(seed) & 32'hff;
      wr(MCSOS_ADDR_WSEL, 8'(r), 1'b0, 3'd0);
      rd(MCSOS_ADDR_WSEL);
      for (int c = 1; c <= 3; c++) begin
         wr(MCSOS_ADDR_WSEL, 8'(c), 1'b0, 3'd0);
         tick(7);
         wr(MCSOS_ADDR_CTRL, 8'h00, 1'b1, 3'd7);
         r = $random(seed) & 32'h7ff;
         tick(r);
         rd(MCSOS_ADDR_STAT);
         tick(lim() - r);
         rd(MCSOS_ADDR_STAT);
         tick(3);
         rd(MCSOS_ADDR_STAT);
         wr(MCSOS_ADDR_CTRL, 8'h80, 1'b0, 3'd0);
         rd(MCSOS_ADDR_STAT);
      end
      cpu_on_crystal = 1'b1;
      wr(MCSOS_ADDR_WSEL, 8'h01, 1'b0, 3'd0);
      wr(MCSOS_ADDR_CTRL, 8'h00, 1'b0, 3'd0);
      tick(100);
      pulse(1'b1);
      rd(MCSOS_ADDR_STAT);
      pulse(1'b0);
      tick(2047);
      outs();
      tick(1);
      outs();
      wr(MCSOS_ADDR_MODE, 8'h04, 1'b0, 3'd0);
      rd(MCSOS_ADDR_MODE);
      wr(MCSOS_ADDR_MODE, 8'h01, 1'b1, 3'd0);
      rd(MCSOS_ADDR_MODE);
      wr(MCSOS_ADDR_MODE, 8'h02, 1'b0, 3'd0);
      rd(MCSOS_ADDR_MODE);
      wr(MCSOS_ADDR_MODE, 8'h00, 1'b1, 3'd2);
      rd(MCSOS_ADDR_MODE);
      // internal clock: no hold, software polls the status instead
      cpu_on_crystal = 1'b0;
      pulse(1'b1);
      pulse(1'b0);
      tick(2048);
      rd(MCSOS_ADDR_STAT);
      // second reset re-arms the one-time source select change
      rst_n = 1'b0;
      step();
      rst_n = 1'b1;
      mreset();
      rd(MCSOS_ADDR_CTRL);
      wr(MCSOS_ADDR_MODE, 8'h04, 1'b0, 3'd0);
      rd(MCSOS_ADDR_MODE);
      conclude();
   end

   // the whole run is about 31k cycles; 60k cycles means a hang
   initial begin
      #600000;
      err_total++;
      conclude();
   end
endmodule // tb
`default_nettype wire
